/* File: common/owcd_pkg.sv */
// package: option word layout, field codes, timing counts and register map
package owcd_pkg;
  // ****************************************
  // word geometry and register map
  // ****************************************
  localparam int OPT_W = 13;
  localparam logic [11:0] ADDR_PRIMARY = 12'h000;
  localparam logic [11:0] ADDR_SECONDARY = 12'h004;
  localparam logic [11:0] ADDR_CUST_ID = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_EXEC = 12'h010;
  localparam logic [11:0] ADDR_CYCLE = 12'h014;
  // ****************************************
  // field positions, primary word
  // ****************************************
  localparam int P_RESET_PIN = 12;
  localparam int P_WDOG = 11;
  localparam int P_CYCLE_LENGTH_SELECT = 10;
  localparam int P_OSC_HI = 9;
  localparam int P_OSC_LO = 8;
  localparam int P_SECURITY = 7;
  localparam int P_SUT_HI = 6;
  localparam int P_SUT_LO = 5;
  localparam int P_TYPE = 4;
  localparam int P_OSC_OUT = 3;
  localparam int P_TRIM_HI = 2;
  // secondary word
  localparam int S_POWER = 2;
  localparam int S_RCM_HI = 1;
  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {OSC_SLOW_XT = 2'b00, OSC_FAST_XT = 2'b01,
    OSC_EXT_RC = 2'b10, OSC_INT_RC = 2'b11} owcd_osc_e;
  typedef enum logic [1:0] {IRC_455K = 2'b00, IRC_1M = 2'b01,
    IRC_8M = 2'b10, IRC_4M = 2'b11} owcd_irc_e;
  localparam logic [1:0] SUT_18MS = 2'b11;
  localparam logic [1:0] SUT_4P5MS = 2'b10;
  localparam logic [1:0] SUT_288MS = 2'b01;
  localparam logic [1:0] SUT_72MS = 2'b00;
  localparam logic [2:0] TRIM_REQUIRED = 3'h7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int SUT_18_US = 18000;
  localparam int SUT_4P5_US = 4500;
  localparam int SUT_288_US = 288000;
  localparam int SUT_72_US = 72000;
  localparam int CYC_18 = SUT_18_US * CLK_MHZ;
  localparam int CYC_4P5 = SUT_4P5_US * CLK_MHZ;
  localparam int CYC_288 = SUT_288_US * CLK_MHZ;
  localparam int CYC_72 = SUT_72_US * CLK_MHZ;
  localparam int OSC_DIV_FAST = 2;
  localparam int OSC_DIV_SLOW = 4;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ext_reset_en;
    logic wdog_en;
    logic four_period;
    owcd_osc_e osc_mode;
    logic code_protect;
    logic [1:0] setup_sel;
    logic osc_out_select;
    logic [2:0] rc_trim_field;
    logic high_power;
    owcd_irc_e irc_freq;
  } owcd_cfg_s;
  typedef struct packed {
    logic pc_write;
    logic jump;
    logic skip_taken;
  } owcd_exec_s;
endpackage : owcd_pkg

/* File: design/owcd_cycle_timer.sv */
// instruction cycle and timer clock divider
`timescale 1ns/1ps
module owcd_cycle_timer
  import owcd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic four_period,
  // strobes
  output logic cycle_tick,
  output logic timer_tick
);
  logic [1:0] phase_q;
  logic last;
  assign last = four_period ? (phase_q == 2'(OSC_DIV_SLOW - 1)) : (phase_q[0] == 1'b1); // [R8]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
    end else if (ce) begin
      if (!run || last) phase_q <= 2'h0;
      else phase_q <= phase_q + 2'h1;
    end
  end

  // timer runs on one pulse per instruction cycle: fosc/2 or fosc/4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_tick <= 1'b0;
      timer_tick <= 1'b0;
    end else if (ce) begin
      cycle_tick <= run && last;
      timer_tick <= run && last; // [R20]
    end
  end

  tick_period_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    ce && run && four_period && cycle_tick |=> !cycle_tick) else $error("cycle tick too fast");
endmodule : owcd_cycle_timer

/* File: design/owcd_top.sv */
// option word decoder top: latch, decode, setup delay, cycle timing, apb view
`timescale 1ns/1ps
// Overview of operation
// R1 - internal rc runs 4 MHz by default; 1 MHz, 8 MHz, 455 kHz selectable
// R2 - frequency field 11 gives 4 MHz, 10 gives 8 MHz
// R3 - option words live outside program memory, not reachable by running code; the customer id word stays readable over apb in any mode
// R4 - three 13-bit words: primary, secondary, customer id
// R5 - primary bit 12 low enables active-low external reset on shared pin
// R6 - primary bit 11 low enables the watchdog
// R7 - pin-change wake needs watchdog option on and runtime watchdog enable off
// R8 - primary bit 10 picks two or four oscillator periods per cycle
// R9 - bits 9:8 pick oscillator mode: irc, erc, fast xtal, slow xtal
// R10 - primary bit 7 low turns code read-out protection on
// R11 - bits 6:5 pick set-up delay 18, 4.5, 288, 72 ms
// R12 - programmer must write type bit 4 as zero
// R13 - primary bit 3 selects port bit or oscillator output on pin
// R14 - programmer must set all three trim bits to one
// R15 - secondary bit 2 low selects low power, high selects high power
// R16 - customer id word is 13 bits with no effect on behaviour
// R17 - instructions are 13-bit words completing normally in one cycle
// R18 - program counter writes take two instruction cycles
// R19 - jumps, calls, returns and taken skips take two cycles
// R20 - timer clock is fosc/4 with four-period cycles, else fosc/2
// R21 - option words latched at power-on before set-up delay, held after
module owcd_top
  import owcd_pkg::*;
#(
  parameter int unsigned SETUP_18 = CYC_18,
  parameter int unsigned SETUP_4P5 = CYC_4P5,
  parameter int unsigned SETUP_288 = CYC_288,
  parameter int unsigned SETUP_72 = CYC_72
)(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // non-volatile option storage
  input wire logic [owcd_pkg::OPT_W-1:0] nv_primary,
  input wire logic [owcd_pkg::OPT_W-1:0] nv_secondary,
  input wire logic [owcd_pkg::OPT_W-1:0] nv_cust_id,
  input wire logic prog_mode,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded configuration
  output owcd_pkg::owcd_cfg_s cfg,
  output logic [owcd_pkg::OPT_W-1:0] customer_id,
  output logic core_run,
  // instruction timing
  output logic instr_done,
  output logic timer_clk_en
);
  import owcd_pkg::*;

  // ****************************************
  // option latch
  // ****************************************
  typedef enum {ST_LATCH, ST_SETUP, ST_RUN} owcd_state_e;
  owcd_state_e state_q;
  logic [OPT_W-1:0] prim_q, sec_q, id_q;
  logic [31:0] setup_cnt_q;
  logic latched;

  // words captured once after reset release; nothing rewrites them later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_q <= '1;
      sec_q <= '1;
      id_q <= '0;
    end else if (ce && state_q == ST_LATCH) begin
      prim_q <= nv_primary; // [R21] [R4]
      sec_q <= nv_secondary; // [R4]
      id_q <= nv_cust_id; // [R16]
    end
  end

  function automatic logic [31:0] setup_count(input logic [1:0] sel);
    case (sel)
      SUT_18MS: setup_count = SETUP_18;
      SUT_4P5MS: setup_count = SETUP_4P5;
      SUT_288MS: setup_count = SETUP_288;
      default: setup_count = SETUP_72;
    endcase
  endfunction : setup_count

  assign latched = (state_q != ST_LATCH);

  // ****************************************
  // set-up delay sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_LATCH;
      setup_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      case (state_q)
        ST_LATCH: begin
          state_q <= ST_SETUP;
          setup_cnt_q <= setup_count(nv_primary[P_SUT_HI:P_SUT_LO]); // [R11] [R21]
        end
        ST_SETUP: begin
          if (setup_cnt_q <= 32'h0000_0001) state_q <= ST_RUN;
          else setup_cnt_q <= setup_cnt_q - 32'h0000_0001;
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_LATCH;
      endcase
    end
  end

  // cycles spent in set-up, kept only so that the delay length can be checked
  logic [31:0] setup_seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_seen_q <= 32'h0000_0000;
    end else if (ce && state_q == ST_SETUP) begin
      setup_seen_q <= setup_seen_q + 32'h0000_0001;
    end
  end

  setup_len_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    ce && state_q == ST_SETUP && setup_cnt_q <= 32'h0000_0001 |->
    setup_seen_q == setup_count(prim_q[P_SUT_HI:P_SUT_LO]) - 32'h0000_0001) else $error("set-up length");

  // ****************************************
  // decode
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
      customer_id <= '0;
      core_run <= 1'b0;
    end else if (ce) begin
      cfg.ext_reset_en <= latched && !prim_q[P_RESET_PIN]; // [R5]
      cfg.wdog_en <= latched && !prim_q[P_WDOG]; // [R6]
      cfg.four_period <= prim_q[P_CYCLE_LENGTH_SELECT]; // [R8]
      cfg.osc_mode <= owcd_osc_e'(prim_q[P_OSC_HI:P_OSC_LO]); // [R9]
      cfg.code_protect <= !prim_q[P_SECURITY]; // [R10]
      cfg.setup_sel <= prim_q[P_SUT_HI:P_SUT_LO]; // [R11]
      cfg.osc_out_select <= prim_q[P_OSC_OUT]; // [R13]
      cfg.rc_trim_field <= prim_q[P_TRIM_HI:0];
      cfg.high_power <= sec_q[S_POWER]; // [R15]
      cfg.irc_freq <= owcd_irc_e'(sec_q[S_RCM_HI:0]); // [R1] [R2]
      customer_id <= id_q; // [R16]
      core_run <= (state_q == ST_RUN);
    end
  end

  // ****************************************
  // instruction cycles
  // ****************************************
  owcd_exec_s exec_q;
  logic second_q, cycle_tick;

  owcd_cycle_timer u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(core_run),
    .four_period(prim_q[P_CYCLE_LENGTH_SELECT]),
    .cycle_tick(cycle_tick),
    .timer_tick(timer_clk_en)
  );

  // one cycle normally; two for pc writes, branches and taken skips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_q <= 1'b0;
      instr_done <= 1'b0;
    end else if (ce) begin
      instr_done <= 1'b0;
      if (cycle_tick) begin
        if (!second_q && (exec_q.pc_write || exec_q.jump || exec_q.skip_taken)) begin // [R18] [R19]
          second_q <= 1'b1;
        end else begin
          second_q <= 1'b0;
          instr_done <= 1'b1; // [R17]
        end
      end
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // primary and secondary words are only visible in programming mode; the customer id reads in any mode
  logic rd_ok;
  assign rd_ok = prog_mode && !(cfg.code_protect && latched); // [R3]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_q <= '0;
    end else if (ce && psel && penable && pwrite && paddr == ADDR_EXEC && pstrb[0]) begin
      exec_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          ADDR_PRIMARY: begin
            prdata <= rd_ok ? 32'(prim_q) : 32'h0000_0000;
            pslverr <= !rd_ok || pwrite;
          end
          ADDR_SECONDARY: begin
            prdata <= rd_ok ? 32'(sec_q) : 32'h0000_0000;
            pslverr <= !rd_ok || pwrite;
          end
          ADDR_CUST_ID: begin
            prdata <= 32'(id_q);
            pslverr <= pwrite;
          end
          ADDR_STATUS: prdata <= {30'h0000_0000, core_run, latched};
          ADDR_EXEC: prdata <= {29'h0000_0000, exec_q};
          ADDR_CYCLE: prdata <= {30'h0000_0000, second_q, prim_q[P_CYCLE_LENGTH_SELECT]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // decode checks wait one edge after the latch, since cfg is registered from the held words
  wdog_decode_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    ce && latched && $stable(prim_q) |=> cfg.wdog_en == !prim_q[P_WDOG])
    else $error("watchdog decode");
  reset_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    ce && latched |=> cfg.ext_reset_en == !prim_q[P_RESET_PIN])
    else $error("reset pin decode");
  words_held_a: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    latched |=> $stable(prim_q) && $stable(sec_q) && $stable(id_q))
    else $error("options changed");
  irc_freq_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    ce && latched |=> cfg.irc_freq == owcd_irc_e'(sec_q[1:0]))
    else $error("irc decode");
  no_run_early_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    state_q != ST_RUN |=> !instr_done)
    else $error("ran before setup");
  two_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    ce && cycle_tick && !second_q && exec_q.jump |=> !instr_done && second_q)
    else $error("branch one cycle");
  one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    ce && cycle_tick && exec_q == '0 |=> instr_done)
    else $error("plain instr slow");
  protect_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ce && psel && !penable && !prog_mode && paddr == ADDR_PRIMARY |=> prdata == 32'h0000_0000)
    else $error("option leak");
  power_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    ce && latched |=> cfg.high_power == sec_q[S_POWER])
    else $error("power decode");
  four_period_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    ce && latched |=> cfg.four_period == prim_q[P_CYCLE_LENGTH_SELECT])
    else $error("cycle length decode");
  osc_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    ce && latched |=> cfg.osc_mode == owcd_osc_e'(prim_q[P_OSC_HI:P_OSC_LO]))
    else $error("oscillator mode decode");
  code_protect_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    ce && latched |=> cfg.code_protect == !prim_q[P_SECURITY])
    else $error("protection decode");
  setup_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    ce && latched |=> cfg.setup_sel == prim_q[P_SUT_HI:P_SUT_LO])
    else $error("set-up select decode");
  osc_out_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    ce && latched |=> cfg.osc_out_select == prim_q[P_OSC_OUT])
    else $error("oscillator output decode");
  cust_id_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    ce && latched |=> customer_id == id_q)
    else $error("customer id copy");
  pc_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    ce && cycle_tick && !second_q && exec_q.pc_write |=> !instr_done && second_q)
    else $error("pc write one cycle");
  skip_taken_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    ce && cycle_tick && !second_q && exec_q.skip_taken |=> !instr_done && second_q)
    else $error("skip one cycle");
  second_done_a: assert property (@(posedge pclk) disable iff (!presetn) // [R18] [R19]
    ce && cycle_tick && second_q |=> instr_done && !second_q)
    else $error("second cycle not ending");
  timer_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    ce && core_run && !prim_q[P_CYCLE_LENGTH_SELECT] && timer_clk_en ##1 ce |-> !timer_clk_en ##1 timer_clk_en)
    else $error("timer rate");
  write_refused_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ce && psel && !penable && pwrite && (paddr == ADDR_PRIMARY || paddr == ADDR_SECONDARY) |=> pslverr)
    else $error("option write accepted");
  run_seen_c: cover property (@(posedge pclk) $rose(core_run));
  branch_c: cover property (@(posedge pclk) cycle_tick && exec_q.pc_write);
  apb_err_c: cover property (@(posedge pclk) pready && pslverr);
  skip_c: cover property (@(posedge pclk) cycle_tick && exec_q.skip_taken);
  freeze_c: cover property (@(posedge pclk) !ce && core_run);
endmodule : owcd_top

/* File: test/owcd_top_test.sv */
// self-checking bench for the option word decoder top
`timescale 1ns/1ps
module owcd_top_test;
  import owcd_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic prog_mode = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [OPT_W-1:0] nv_p = '0;
  logic [OPT_W-1:0] nv_s = '0;
  logic [OPT_W-1:0] nv_c = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  owcd_cfg_s cfg;
  logic [OPT_W-1:0] customer_id;
  logic core_run;
  logic instr_done;
  logic timer_clk_en;
  int err_total = 0;
  int checks = 0;

  always #4 pclk = ~pclk;

  // short set-up counts keep the run far below the real millisecond delays
  owcd_top #(.SETUP_18(10), .SETUP_4P5(5), .SETUP_288(40), .SETUP_72(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .nv_primary(nv_p), .nv_secondary(nv_s), .nv_cust_id(nv_c), .prog_mode(prog_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .customer_id(customer_id), .core_run(core_run),
    .instr_done(instr_done), .timer_clk_en(timer_clk_en)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task hang(input string name);
    err_total++;
    $display("MISMATCH %s expected response seen timeout", name);
    end_of_test();
  endtask : hang

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) hang("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cycles between two pulses of the timer strobe or of instruction end
  task gap(input bit tmr, output int g);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 200) hang("pulse");
    end while ((tmr ? timer_clk_en : instr_done) !== 1'b1);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
      if (g > 200) hang("pulse");
    end while ((tmr ? timer_clk_en : instr_done) !== 1'b1);
  endtask : gap

  // clock enable low must hold the timer strobe and instruction end where they stood
  task freeze;
    logic [1:0] v;
    ce <= 1'b0;
    @(posedge pclk);
    v = {timer_clk_en, instr_done};
    repeat (6) begin
      @(posedge pclk);
      chk("freeze", 32'(v), 32'({timer_clk_en, instr_done}));
    end
    ce <= 1'b1;
  endtask : freeze

  // ****************************************
  // scenario: one option setting, from reset to instruction timing
  // ****************************************
  task run_cfg(input int i);
    logic [12:0] p;
    logic [12:0] s;
    logic [12:0] c;
    owcd_cfg_s e;
    logic [31:0] rd;
    logic er;
    int n;
    int g;
    int lim;
    int base;
    // type bit kept 0, trim bits all 1; watchdog option stays on whenever i[1] is 0
    p = {~i[0], i[1], i[0], i[1:0], ~i[1], i[1:0], 1'b0, i[0], 3'b111};
    s = {10'h000, i[0], i[1:0]};
    c = 13'h1a5c ^ 13'(i);
    e = {~p[12], ~p[11], p[10], p[9:8], ~p[7], p[6:5], p[3], p[2:0], s[2], s[1:0]};
    lim = (p[6:5] == SUT_18MS) ? 10 : (p[6:5] == SUT_4P5MS) ? 5 : (p[6:5] == SUT_288MS) ? 40 : 20;
    base = p[10] ? 4 : 2;
    presetn <= 1'b0;
    nv_p <= p;
    nv_s <= s;
    nv_c <= c;
    prog_mode <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (core_run !== 1'b1) begin
      @(posedge pclk);
      n++;
      // storage changes after the latch edge must not reach the decode
      if (n == 2) nv_p <= ~p;
      if (n == 2) nv_s <= ~s;
      if (n > 100) hang("core_run");
    end
    chk("setup_len", 32'h0000_0001, 32'(n >= lim && n <= lim + 5));
    chk("cfg", 32'(e), 32'(cfg));
    chk("cust", 32'(c), 32'(customer_id));
    apb(1'b0, ADDR_CUST_ID, 32'h0000_0000, rd, er);
    chk("cust_rd", 32'(c), rd);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
    chk("status_rd", 32'h0000_0003, rd);
    chk("status_err", 32'h0000_0000, 32'(er));
    apb(1'b0, ADDR_CYCLE, 32'h0000_0000, rd, er);
    chk("cycle_rd", 32'(p[10]), rd);
    apb(1'b0, ADDR_PRIMARY, 32'h0000_0000, rd, er);
    chk("prim_rd", p[7] ? 32'(p) : 32'h0000_0000, rd);
    chk("prim_err", 32'(!p[7]), 32'(er));
    prog_mode <= 1'b0;
    apb(1'b0, ADDR_SECONDARY, 32'h0000_0000, rd, er);
    chk("sec_err", 32'h0000_0001, 32'(er));
    apb(1'b1, ADDR_PRIMARY, 32'h0000_1fff, rd, er);
    chk("wr_err", 32'h0000_0001, 32'(er));
    apb(1'b0, 12'hffc, 32'h0000_0000, rd, er);
    chk("unmapped_err", 32'h0000_0001, 32'(er));
    gap(1'b1, g);
    chk("timer_gap", 32'(base), 32'(g));
    freeze();
    gap(1'b0, g);
    chk("instr_gap", 32'(base), 32'(g));
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_EXEC, 32'(1 << k), rd, er);
      chk("exec_err", 32'h0000_0000, 32'(er));
      apb(1'b0, ADDR_EXEC, 32'h0000_0000, rd, er);
      chk("exec_rd", 32'(1 << k), rd);
      // the first pulse after the write may end an instruction begun before it
      gap(1'b0, g);
      gap(1'b0, g);
      chk("instr_two", 32'(2 * base), 32'(g));
    end
    apb(1'b1, ADDR_EXEC, 32'h0000_0000, rd, er);
  endtask : run_cfg

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 4; i++) begin
      run_cfg(i);
    end
    end_of_test();
  end
endmodule : owcd_top_test
